// File: rtl/pcc_defines.svh
// offsets, field positions, encodings and reset values of the capability logic
`ifndef PCC_DEFINES_SVH
`define PCC_DEFINES_SVH

// ----------------------------------------------------------------------
// configuration space offsets
// ----------------------------------------------------------------------
`define PCC_DEVCAP_OFF     12'h084
`define PCC_DEVCTL_OFF     12'h088
`define PCC_DEVCTL2_OFF    12'h0a8

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PCC_MPS_LSB        0
`define PCC_MPS_MSB        2
`define PCC_EXT_TAG_SUP    5
`define PCC_EXT_TAG_EN     8
`define PCC_CTO_VAL_LSB    0
`define PCC_CTO_VAL_MSB    3
`define PCC_CTO_DIS        4

// ----------------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------------
`define PCC_DEVCTL_RST     16'h0000
`define PCC_DEVCTL2_RST    16'h0000
`define PCC_DEVCTL_WMASK   16'hffff
`define PCC_DEVCTL2_WMASK  16'h001f

// ----------------------------------------------------------------------
// steering tag table location codes
// ----------------------------------------------------------------------
`define PCC_ST_LOC_NONE    2'h0
`define PCC_ST_LOC_TPH     2'h1
`define PCC_ST_LOC_MSIX    2'h2
`define PCC_ST_SIZE_MAX    2047

// ----------------------------------------------------------------------
// payload size codes, 128 to 2048 bytes
// ----------------------------------------------------------------------
`define PCC_MPS_128        3'h0
`define PCC_MPS_256        3'h1
`define PCC_MPS_512        3'h2
`define PCC_MPS_1024       3'h3
`define PCC_MPS_2048       3'h4

// ----------------------------------------------------------------------
// completion timeout range sets
// ----------------------------------------------------------------------
`define PCC_CTO_NONE       4'h0
`define PCC_CTO_A          4'h1
`define PCC_CTO_B          4'h2
`define PCC_CTO_AB         4'h3
`define PCC_CTO_BC         4'h6
`define PCC_CTO_ABC        4'h7
`define PCC_CTO_BCD        4'he
`define PCC_CTO_ABCD       4'hf

// ----------------------------------------------------------------------
// completion timeout range bounds, timed by the application
// ----------------------------------------------------------------------
`define PCC_CTO_A_MIN_US   50
`define PCC_CTO_A_MAX_MS   10
`define PCC_CTO_B_MAX_MS   250
`define PCC_CTO_C_MAX_S    4
`define PCC_CTO_D_MAX_S    64

// ----------------------------------------------------------------------
// tag tracking
// ----------------------------------------------------------------------
`define PCC_BASE_TAGS      32
`define PCC_TAG_W          6

`endif

// File: rtl/pcc_pkg.sv
// types shared by the capability configuration logic
package pcc_pkg;
  typedef logic [15:0] pcc_st_t;
  typedef logic [10:0] pcc_st_idx_t;
  typedef logic [5:0]  pcc_tag_t;
  typedef logic [1:0]  pcc_pf_t;
endpackage

// File: rtl/pcc_st_table.sv
// steering tag table storage, one write port and a registered read port
module pcc_st_table
  import pcc_pkg::*;
#(
  parameter int DEPTH = 2048
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // write port
  input  wire logic        wr_en,
  input  wire pcc_st_idx_t wr_idx,
  input  wire pcc_st_t     wr_data,
  // read port
  input  wire logic        rd_en,
  input  wire pcc_st_idx_t rd_idx,
  output pcc_st_t          rd_data_q
);

  pcc_st_t mem [DEPTH];

  always_ff @(posedge ref_clk) begin
    if (wr_en && (int'(wr_idx) < DEPTH)) begin
      mem[wr_idx] <= wr_data;
    end
  end

  // read data out of a register so the caller sees a fixed one-cycle latency
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rd_data_q <= 16'h0000;
    end else if (rd_en) begin
      rd_data_q <= (int'(rd_idx) < DEPTH) ? mem[rd_idx] : 16'h0000;
    end
  end

endmodule

// File: rtl/pcc_capability_config.sv
// capability configuration: steering tags, invalidate limits, payload size, tags
`include "pcc_defines.svh"

module pcc_capability_config
  import pcc_pkg::*;
#(
  parameter int         NUM_PF       = 4,
  parameter bit         TPH_INT_MODE = 1'b0,
  parameter bit         TPH_DEV_MODE = 1'b0,
  parameter logic [1:0] ST_TABLE_LOC = `PCC_ST_LOC_NONE,
  parameter int         ST_TABLE_SIZE = 0,
  parameter int         MAX_INV_OUT  = 32,
  parameter logic [2:0] MAX_PAYLOAD  = `PCC_MPS_128,
  parameter int         NUM_TAGS     = 32,
  parameter logic [3:0] CTO_RANGES   = `PCC_CTO_ABCD
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  // configuration space access
  input  wire logic              cfg_rd,
  input  wire logic              cfg_wr,
  input  wire logic [11:0]       cfg_addr,
  input  wire logic [3:0]        cfg_be,
  input  wire logic [31:0]       cfg_wdata,
  output logic [31:0]            cfg_rdata_q,
  output logic                   cfg_rvalid_q,
  // steering tag table load
  input  wire logic              st_wr_en,
  input  wire pcc_st_idx_t       st_wr_idx,
  input  wire pcc_st_t           st_wr_data,
  // steering tag lookup for hinted requests
  input  wire logic              st_req,
  input  wire pcc_st_idx_t       st_req_vec,
  input  wire pcc_st_idx_t       st_req_idx,
  output logic                   st_rsp_valid_q,
  output pcc_st_t                st_rsp_tag_q,
  // invalidate requests in, cache invalidations out
  input  wire logic              inv_valid,
  input  wire pcc_pf_t           inv_pf,
  input  wire logic [63:0]       inv_addr,
  input  wire logic [31:0]       inv_size,
  input  wire logic [NUM_PF-1:0] inv_done,
  output logic [NUM_PF-1:0]      inv_ready_q,
  output logic                   atc_inv_valid_q,
  output pcc_pf_t                atc_inv_pf_q,
  output logic [63:0]            atc_inv_addr_q,
  output logic [31:0]            atc_inv_size_q,
  // non-posted tag tracking
  input  wire logic              np_valid,
  input  wire pcc_tag_t          np_tag,
  input  wire logic              cpl_valid,
  input  wire pcc_tag_t          cpl_tag,
  input  wire logic              cpl_last,
  output logic                   np_tag_err_q,
  output logic [6:0]             tags_outstanding_q,
  // settings seen by the application
  output logic                   ext_tag_en_q,
  output logic [3:0]             cto_ranges_q,
  output logic [3:0]             cto_value_q,
  output logic                   cto_disable_q
);

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  localparam bit EXT_TAG_SUP = (NUM_TAGS > `PCC_BASE_TAGS);

  logic [15:0] devctl_q;
  logic [15:0] devctl2_q;

  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0]  be,
                                          input logic [15:0] wmask);
    logic [15:0] m;
    m = {{8{be[1]}}, {8{be[0]}}} & wmask;
    return (old_v & ~m) | (new_v & m);
  endfunction

  function automatic logic [31:0] read_reg(input logic [11:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      `PCC_DEVCAP_OFF: begin
        v[`PCC_MPS_MSB:`PCC_MPS_LSB] = MAX_PAYLOAD;
        v[`PCC_EXT_TAG_SUP]          = EXT_TAG_SUP;
      end
      `PCC_DEVCTL_OFF:  v[15:0] = devctl_q;
      `PCC_DEVCTL2_OFF: v[15:0] = devctl2_q;
      default:          v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      devctl_q <= `PCC_DEVCTL_RST;
    end else if (cfg_wr && cfg_addr == `PCC_DEVCTL_OFF) begin
      devctl_q <= merge16(devctl_q, cfg_wdata[15:0], cfg_be[1:0], `PCC_DEVCTL_WMASK);
    end
  end

  // timeout controls only take writes when some range is advertised
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      devctl2_q <= `PCC_DEVCTL2_RST;
    end else if (cfg_wr && cfg_addr == `PCC_DEVCTL2_OFF && CTO_RANGES != `PCC_CTO_NONE) begin
      devctl2_q <= merge16(devctl2_q, cfg_wdata[15:0], cfg_be[1:0], `PCC_DEVCTL2_WMASK);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cfg_rdata_q  <= 32'h0000_0000;
      cfg_rvalid_q <= 1'b0;
    end else begin
      cfg_rvalid_q <= cfg_rd;
      cfg_rdata_q  <= cfg_rd ? read_reg(cfg_addr) : 32'h0000_0000;
    end
  end

  // the timer lives in the application; only the settings are handed over
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ext_tag_en_q  <= 1'b0;
      cto_ranges_q  <= 4'h0;
      cto_value_q   <= 4'h0;
      cto_disable_q <= 1'b0;
    end else begin
      ext_tag_en_q  <= devctl_q[`PCC_EXT_TAG_EN];
      cto_ranges_q  <= CTO_RANGES;
      cto_value_q   <= devctl2_q[`PCC_CTO_VAL_MSB:`PCC_CTO_VAL_LSB];
      cto_disable_q <= devctl2_q[`PCC_CTO_DIS];
    end
  end

  // ----------------------------------------------------------------------
  // steering tag selection
  // ----------------------------------------------------------------------
  pcc_st_idx_t st_sel_idx;
  logic        st_hit;
  logic        st_req_q;
  logic        st_hit_q;
  pcc_st_t     st_mem_data;

  // interrupt mode wins when both are enabled; out-of-table index gives tag 0
  always_comb begin
    st_sel_idx = 11'h000;
    if (TPH_INT_MODE) begin
      st_sel_idx = st_req_vec;
    end else if (TPH_DEV_MODE) begin
      st_sel_idx = st_req_idx;
    end
    st_hit = (TPH_INT_MODE || TPH_DEV_MODE)
          && (ST_TABLE_LOC != `PCC_ST_LOC_NONE)
          && (int'(st_sel_idx) < ST_TABLE_SIZE);
  end

  // one table for all functions, whether it sits in the capability or msi-x
  pcc_st_table #(
    .DEPTH (`PCC_ST_SIZE_MAX + 1)
  ) u_st_table (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .wr_en     (st_wr_en && ST_TABLE_LOC != `PCC_ST_LOC_NONE),
    .wr_idx    (st_wr_idx),
    .wr_data   (st_wr_data),
    .rd_en     (st_req && st_hit),
    .rd_idx    (st_sel_idx),
    .rd_data_q (st_mem_data)
  );

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st_req_q       <= 1'b0;
      st_hit_q       <= 1'b0;
      st_rsp_valid_q <= 1'b0;
      st_rsp_tag_q   <= 16'h0000;
    end else begin
      st_req_q       <= st_req;
      st_hit_q       <= st_hit;
      st_rsp_valid_q <= st_req_q;
      st_rsp_tag_q   <= (st_req_q && st_hit_q) ? st_mem_data : 16'h0000;
    end
  end

  // ----------------------------------------------------------------------
  // invalidate request limiting, one counter per function
  // ----------------------------------------------------------------------
  localparam logic [5:0] INV_LIMIT = 6'(MAX_INV_OUT);

  genvar g;
  generate
    for (g = 0; g < NUM_PF; g++) begin : g_pf
      logic [5:0] cnt_q;
      logic [5:0] cnt_d;
      logic       inc;
      logic       dec;
      always_comb begin
        inc   = inv_valid && inv_ready_q[g] && (int'(inv_pf) == g);
        dec   = inv_done[g] && (cnt_q != 6'h00);
        cnt_d = cnt_q + {5'h00, inc} - {5'h00, dec};
      end
      always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
          cnt_q          <= 6'h00;
          inv_ready_q[g] <= 1'b0;
        end else begin
          cnt_q          <= cnt_d;
          inv_ready_q[g] <= (cnt_d < INV_LIMIT);
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      atc_inv_valid_q <= 1'b0;
      atc_inv_pf_q    <= 2'h0;
      atc_inv_addr_q  <= 64'h0000_0000_0000_0000;
      atc_inv_size_q  <= 32'h0000_0000;
    end else begin
      atc_inv_valid_q <= inv_valid && inv_ready_q[inv_pf];
      if (inv_valid && inv_ready_q[inv_pf]) begin
        atc_inv_pf_q   <= inv_pf;
        atc_inv_addr_q <= inv_addr;
        atc_inv_size_q <= inv_size;
      end
    end
  end

  // ----------------------------------------------------------------------
  // non-posted tag tracking
  // ----------------------------------------------------------------------
  localparam logic [6:0] TAG_LIMIT = 7'(NUM_TAGS);

  logic [63:0] tag_busy_q;
  logic        tag_ok;
  logic        tag_alloc;
  logic        tag_free;

  always_comb begin
    tag_ok    = ({1'b0, np_tag} < TAG_LIMIT)
             && (np_tag < 6'd32 || devctl_q[`PCC_EXT_TAG_EN])
             && !tag_busy_q[np_tag];
    tag_alloc = np_valid && tag_ok;
    tag_free  = cpl_valid && cpl_last && tag_busy_q[cpl_tag];
  end

  // clear first, then set, so a new claim in the same cycle is kept
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      tag_busy_q <= 64'h0000_0000_0000_0000;
    end else begin
      if (tag_free) begin
        tag_busy_q[cpl_tag] <= 1'b0;
      end
      if (tag_alloc) begin
        tag_busy_q[np_tag] <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      tags_outstanding_q <= 7'h00;
      np_tag_err_q       <= 1'b0;
    end else begin
      tags_outstanding_q <= tags_outstanding_q + {6'h00, tag_alloc} - {6'h00, tag_free};
      np_tag_err_q       <= np_valid && !tag_ok;
    end
  end

endmodule

// File: test/pcc_app_model.sv
// application-side model that finishes cache invalidations after a delay
module pcc_app_model #(
  parameter int NUM_PF = 4,
  parameter int DLY    = 20
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  // invalidations from the device, completions back
  input  wire logic              atc_inv_valid_q,
  input  wire logic [1:0]        atc_inv_pf_q,
  output logic [NUM_PF-1:0]      inv_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [NUM_PF-1:0] pipe_q [DLY];
  // a long fixed delay keeps the outstanding count at its limit for a while
  always_ff @(posedge ref_clk) begin
    pipe_q[0] <= (reset_n && atc_inv_valid_q) ? NUM_PF'(1) << atc_inv_pf_q : '0;
    for (int i = 1; i < DLY; i++) begin
      pipe_q[i] <= reset_n ? pipe_q[i-1] : '0;
    end
  end
  assign inv_done = pipe_q[DLY-1];
endmodule

// File: test/pcc_capability_config_checker.sv
// concurrent checks on the capability configuration ports
`include "pcc_defines.svh"
module pcc_capability_config_checker
  import pcc_pkg::*;
#(
  parameter logic [2:0] MAX_PAYLOAD = 3'h0,
  parameter int         NUM_TAGS    = 32,
  parameter logic [3:0] CTO_RANGES  = 4'hf
) (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        cfg_rd,
  input wire logic [11:0] cfg_addr,
  input wire logic [31:0] cfg_rdata_q,
  input wire logic        cfg_rvalid_q,
  input wire logic        st_req,
  input wire logic        st_rsp_valid_q,
  input wire logic        inv_valid,
  input wire pcc_pf_t     inv_pf,
  input wire logic [3:0]  inv_ready_q,
  input wire logic        atc_inv_valid_q,
  input wire pcc_pf_t     atc_inv_pf_q,
  input wire logic        np_valid,
  input wire pcc_tag_t    np_tag,
  input wire logic        np_tag_err_q,
  input wire logic        cpl_valid,
  input wire logic        cpl_last,
  input wire logic [6:0]  tags_outstanding_q,
  input wire logic        ext_tag_en_q,
  input wire logic [3:0]  cto_ranges_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  rd_answer_a: assert property (cfg_rvalid_q == $past(cfg_rd)) else $error("read answer");
  rdata_idle_a: assert property (!cfg_rvalid_q |-> cfg_rdata_q == 32'h0) else $error("idle rdata");
  cap_fields_a: assert property (cfg_rd && cfg_addr == `PCC_DEVCAP_OFF |=>
    cfg_rdata_q[2:0] == MAX_PAYLOAD && cfg_rdata_q[5] == (NUM_TAGS > 32)) else $error("devcap");
  st_latency_a: assert property (st_req |-> ##2 st_rsp_valid_q) else $error("steer latency");
  inv_taken_a: assert property (inv_valid && inv_ready_q[inv_pf] |=>
    atc_inv_valid_q && atc_inv_pf_q == $past(inv_pf)) else $error("inv accept");
  inv_held_a: assert property (!(inv_valid && inv_ready_q[inv_pf]) |=> !atc_inv_valid_q) else $error("inv backpressure");
  big_tag_a: assert property (np_valid && np_tag >= NUM_TAGS |=> np_tag_err_q) else $error("tag range");
  ext_need_a: assert property ((np_valid && np_tag[5] && !ext_tag_en_q) ##1 !ext_tag_en_q
    |-> np_tag_err_q) else $error("ext tag");
  tag_count_a: assert property (np_valid && !cpl_valid |=>
    np_tag_err_q || tags_outstanding_q == $past(tags_outstanding_q) + 7'h1) else $error("tag count");
  tag_free_a: assert property (cpl_valid && cpl_last && !np_valid |=>
    tags_outstanding_q <= $past(tags_outstanding_q)) else $error("tag free");
  cto_fixed_a: assert property ($past(reset_n) |-> cto_ranges_q == CTO_RANGES) else $error("cto ranges");
endmodule
bind pcc_capability_config pcc_capability_config_checker #(.MAX_PAYLOAD(MAX_PAYLOAD),
  .NUM_TAGS(NUM_TAGS), .CTO_RANGES(CTO_RANGES)) chk_i (.ref_clk, .reset_n, .cfg_rd, .cfg_addr,
  .cfg_rdata_q, .cfg_rvalid_q, .st_req, .st_rsp_valid_q, .inv_valid, .inv_pf, .inv_ready_q,
  .atc_inv_valid_q, .atc_inv_pf_q, .np_valid, .np_tag, .np_tag_err_q, .cpl_valid, .cpl_last,
  .tags_outstanding_q, .ext_tag_en_q, .cto_ranges_q);

// File: test/tb_pcie_capability_config.sv
// self-checking bench for the capability configuration block
`include "pcc_defines.svh"
module tb_pcie_capability_config;
  import pcc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, reset_n = 0, cfg_rd = 0, cfg_wr = 0, st_wr_en = 0, st_req = 0;
  logic [11:0] cfg_addr = 0;
  logic [3:0] cfg_be = 0, inv_done, inv_ready_q;
  logic [31:0] cfg_wdata = 0, cfg_rdata_q, inv_size = 0, atc_inv_size_q, lfsr = 32'h1ef139f8;
  logic cfg_rvalid_q, st_rsp_valid_q, inv_valid = 0, atc_inv_valid_q, np_valid = 0;
  logic cpl_valid = 0, cpl_last = 0, np_tag_err_q, ext_tag_en_q, cto_disable_q;
  pcc_st_idx_t st_wr_idx = 0, st_req_vec = 0, st_req_idx = 0;
  pcc_st_t st_wr_data = 0, st_rsp_tag_q, exp_st [18];
  pcc_pf_t inv_pf = 0, atc_inv_pf_q;
  logic [63:0] inv_addr = 0, atc_inv_addr_q;
  pcc_tag_t np_tag = 0, cpl_tag = 0;
  logic [6:0] tags_outstanding_q, exp_cnt;
  logic [3:0] cto_ranges_q, cto_value_q;
  logic busy [64];
  logic [31:0] rd;
  int bad_count = 0, samples_checked = 0;
  pcc_capability_config #(.TPH_DEV_MODE(1'b1), .ST_TABLE_LOC(`PCC_ST_LOC_TPH), .ST_TABLE_SIZE(16),
    .MAX_INV_OUT(2), .NUM_TAGS(64)) uut (.ref_clk, .reset_n, .cfg_rd,
    .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata_q, .cfg_rvalid_q, .st_wr_en, .st_wr_idx,
    .st_wr_data, .st_req, .st_req_vec, .st_req_idx, .st_rsp_valid_q, .st_rsp_tag_q, .inv_valid,
    .inv_pf, .inv_addr, .inv_size, .inv_done, .inv_ready_q, .atc_inv_valid_q, .atc_inv_pf_q,
    .atc_inv_addr_q, .atc_inv_size_q, .np_valid, .np_tag, .cpl_valid, .cpl_tag, .cpl_last,
    .np_tag_err_q, .tags_outstanding_q, .ext_tag_en_q, .cto_ranges_q, .cto_value_q, .cto_disable_q);
  pcc_app_model app_i (.ref_clk, .reset_n, .atc_inv_valid_q,
    .atc_inv_pf_q, .inv_done);
  initial forever #50 ref_clk = ~ref_clk;
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    if (bad_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cfg_read(input logic [11:0] a);
    @(posedge ref_clk) begin cfg_rd <= 1; cfg_addr <= a; end
    @(posedge ref_clk) cfg_rd <= 0;
    #1 rd = cfg_rdata_q;
  endtask
  task automatic cfg_write(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge ref_clk) begin cfg_wr <= 1; cfg_addr <= a; cfg_be <= be; cfg_wdata <= d; end
    @(posedge ref_clk) cfg_wr <= 0;
  endtask
  task automatic inv_send(input pcc_pf_t p, input logic [63:0] a);
    logic r;
    @(posedge ref_clk) begin inv_valid <= 1; inv_pf <= p; inv_addr <= a; inv_size <= lfsr; end
    for (int i = 0; i < 200; i++) begin
      #1 r = inv_ready_q[p];
      @(posedge ref_clk);
      if (r) break;
    end
    inv_valid <= 0;
    #1 chk({atc_inv_valid_q, atc_inv_addr_q}, {1'b1, a});
    chk({atc_inv_pf_q, atc_inv_size_q}, {p, lfsr});
  endtask
  task automatic np_send(input pcc_tag_t t, input logic exp_err);
    @(posedge ref_clk) begin np_valid <= 1; np_tag <= t; end
    @(posedge ref_clk) np_valid <= 0;
    #1 chk(np_tag_err_q, exp_err);
    if (!exp_err) begin busy[t] = 1; exp_cnt++; end
    chk(tags_outstanding_q, exp_cnt);
  endtask
  task automatic cpl_send(input pcc_tag_t t, input logic last);
    @(posedge ref_clk) begin cpl_valid <= 1; cpl_tag <= t; cpl_last <= last; end
    @(posedge ref_clk) cpl_valid <= 0;
    if (last && busy[t]) begin busy[t] = 0; exp_cnt--; end
    #1 chk(tags_outstanding_q, exp_cnt);
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    final_report();
  end
  initial begin
    foreach (busy[i]) busy[i] = 0;
    exp_cnt = 0;
    repeat (12) @(posedge ref_clk);
    reset_n <= 1;
    cfg_read(`PCC_DEVCAP_OFF);
    chk({rd[5], rd[2:0]}, {1'b1, `PCC_MPS_128});
    cfg_write(`PCC_DEVCAP_OFF, 4'hf, 32'hffffffff);
    cfg_read(`PCC_DEVCAP_OFF);
    chk({rd[5], rd[2:0]}, {1'b1, `PCC_MPS_128});
    cfg_read(12'h0fc);
    chk(rd, 0);
    chk(cto_ranges_q, `PCC_CTO_ABCD);
    lfsr = next_rand(lfsr);
    cfg_write(`PCC_DEVCTL2_OFF, 4'h3, lfsr);
    cfg_read(`PCC_DEVCTL2_OFF);
    chk(rd, lfsr[15:0] & `PCC_DEVCTL2_WMASK);
    chk({cto_disable_q, cto_value_q}, lfsr[4:0]);
    for (int i = 0; i < 18; i++) begin
      lfsr = next_rand(lfsr);
      exp_st[i] = (i < 16) ? lfsr[15:0] : 16'h0;
      @(posedge ref_clk) begin st_wr_en <= 1; st_wr_idx <= 11'(i); st_wr_data <= lfsr[15:0]; end
    end
    @(posedge ref_clk) st_wr_en <= 0;
    for (int i = 17; i >= 0; i--) begin
      @(posedge ref_clk) begin st_req <= 1; st_req_idx <= 11'(i); st_req_vec <= ~11'(i); end
      @(posedge ref_clk) st_req <= 0;
      @(posedge ref_clk);
      #1 chk({st_rsp_valid_q, st_rsp_tag_q}, {1'b1, exp_st[i]});
    end
    inv_send(2'h0, 64'h1000);
    inv_send(2'h0, 64'h2000);
    @(posedge ref_clk);
    #1 chk(inv_ready_q[1:0], 2'b10);
    lfsr = next_rand(lfsr);
    inv_send(2'h1, {lfsr, 32'h0});
    inv_send(2'h0, 64'h3000);
    np_send(6'd40, 1);
    cfg_write(`PCC_DEVCTL_OFF, 4'h1, 32'hffff);
    cfg_read(`PCC_DEVCTL_OFF);
    chk(rd, 32'h00ff);
    chk(ext_tag_en_q, 0);
    cfg_write(`PCC_DEVCTL_OFF, 4'h3, 32'h0100);
    np_send(6'd40, 0);
    chk(ext_tag_en_q, 1);
    np_send(6'd40, 1);
    np_send(6'd63, 0);
    cpl_send(6'd40, 0);
    cpl_send(6'd40, 1);
    for (int i = 0; i < 40; i++) begin
      lfsr = next_rand(lfsr);
      np_send(lfsr[5:0], busy[lfsr[5:0]]);
      cpl_send(lfsr[13:8], lfsr[20]);
    end
    final_report();
  end
endmodule
